// ### orsq_consts.vh
`ifndef ORSQ_CONSTS_VH
`define ORSQ_CONSTS_VH
// Source bit positions
`define ORSQ_SRC_LPK      0
`define ORSQ_SRC_PDN      1
`define ORSQ_SRC_WDG      2
`define ORSQ_SRC_THM      3
`define ORSQ_SRC_RSTIN    4
`define ORSQ_SRC_SWRST    5
`define ORSQ_SRC_LOWV     6
`define ORSQ_SRC_ADC      7
// Reset values
`define ORSQ_SCOPE_RST    8'h7d
`define ORSQ_RESTART_RST  8'h34
`define ORSQ_DLY_RST      2'h0
`define ORSQ_AUTOON_RST   1'b0
`define ORSQ_WDHOLD_RST   1'b1
`define ORSQ_PDFAST_RST   1'b0
`define ORSQ_THFAST_RST   1'b0
// Timing
`define ORSQ_STEP_CYC     16'h0010
`define ORSQ_FAST_CYC     16'h0001
`define ORSQ_DLY_UNIT_CYC 16'h0400
`endif

// ### orsq_step_timer.v
`timescale 1ns/1ps
module orsq_step_timer #(
  parameter WIDTH = 16
) (
  input  wire             clk_i,   // Clock
  input  wire             rstn_i,  // Async reset, low
  input  wire             start_i, // Load and run
  input  wire [WIDTH-1:0] load_i,  // Cycles to count
  output wire             done_o   // Expired, level
);
  reg [WIDTH-1:0] cnt;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= {WIDTH{1'b0}};
    end else if (start_i) begin
      cnt <= load_i;
    end else if (cnt != {WIDTH{1'b0}}) begin
      cnt <= cnt - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
  assign done_o = (cnt == {WIDTH{1'b0}}) & ~start_i;
endmodule

// ### orsq_top.v
// Operation
// - Full-reset request from ACTIVE/SLEEP goes OFF
// - Non-full request resets only switchoff domain
// - Regulator level and mode in switchoff domain
// - Eight reset-scope bits, one selects full
// - Scope defaults: powerdown, converter switchoff only
// - Shutdown request sequences off, stays OFF
// - Cold restart returns ACTIVE unless gated
// - Eight restart bits; watchdog, resetin, software cold
// - ON request in OFF runs enable sequence
// - OFF request in ACTIVE runs disable sequence
// - Sequences drive regulators, GPIOs, enables automatically
// - Switchoff delay holds enables on in DELAY; default none
// - Auto-on sets device-on after startup
// - Watchdog hold in SLEEP, default on
// - Powerdown fast-off zero means sequenced off
// - Thermal fast-off zero means sequenced off
// - Low supply forces BACKUP from any state
`timescale 1ns/1ps
`include "orsq_consts.vh"
module orsq_top #(
  parameter NRES      = 8,                  // Sequenced resources
  parameter DLY_UNIT  = `ORSQ_DLY_UNIT_CYC  // Cycles per delay step
) (
  input  wire            CLK_I,            // 40 MHz clock
  input  wire            RSTN_I,           // Async reset, low
  input  wire [7:0]      OFF_REQ_I,        // OFF request pulses per source
  input  wire            ON_REQ_I,         // ON request pulse
  input  wire            ON_GATE_I,        // ON gating condition present
  input  wire            SLEEP_REQ_I,      // Enter SLEEP level
  input  wire            LOW_SUPPLY_I,     // Supply below threshold, pin
  input  wire            SUPPLY_OK_I,      // Supply above threshold, pin
  input  wire            DEVICE_ON_CLR_I,  // Software clear of device-on
  input  wire            CFG_WE_I,         // Config write strobe
  input  wire [7:0]      SCOPE_WDATA_I,    // Reset-scope bits
  input  wire [7:0]      RESTART_WDATA_I,  // Restart-select bits
  input  wire [1:0]      DLY_WDATA_I,      // Switchoff delay field
  input  wire [3:0]      OPT_WDATA_I,      // Auto-on, wd hold, pd fast, th fast
  output wire [7:0]      SCOPE_O,          // Reset-scope readback
  output wire [7:0]      RESTART_O,        // Restart-select readback
  output wire [1:0]      DLY_O,            // Switchoff delay readback
  output wire [3:0]      OPT_O,            // Options readback
  output reg  [2:0]      STATE_O,          // Power state
  output reg  [NRES-1:0] RES_EN_O,         // Resource enables
  output reg  [NRES-1:0] RES_SLEEP_O,      // Resource sleep modes
  output reg             DEVICE_ON_O,      // Device-on bit
  output reg             FULL_RST_O,       // Full reset pulse
  output reg             SWOFF_RST_O,      // Switchoff-domain reset pulse
  output reg             WDT_RUN_O,        // Watchdog may count
  output reg  [7:0]      ACTIVE_SRC_O      // Latched OFF source
);
  // ****************************************
  // States
  // ****************************************
  localparam ST_BACKUP = 3'h0;
  localparam ST_OFF    = 3'h1;
  localparam ST_ON_SEQ = 3'h2;
  localparam ST_ACTIVE = 3'h3;
  localparam ST_SLEEP  = 3'h4;
  localparam ST_DELAY  = 3'h5;
  localparam ST_OFFSEQ = 3'h6;
  localparam ST_RESET  = 3'h7;

  // ****************************************
  // Supply pin synchronisers
  // ****************************************
  reg [2:0] low_sync;
  reg [2:0] ok_sync;
  reg       low_supply;
  reg       supply_ok;
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      low_sync   <= 3'h7;
      ok_sync    <= 3'h0;
      low_supply <= 1'b1;
      supply_ok  <= 1'b0;
    end else begin
      low_sync <= {low_sync[1:0], LOW_SUPPLY_I};
      ok_sync  <= {ok_sync[1:0], SUPPLY_OK_I};
      if (low_sync[2] == low_sync[1]) begin
        low_supply <= low_sync[2];
      end
      if (ok_sync[2] == ok_sync[1]) begin
        supply_ok <= ok_sync[2];
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  reg [7:0] scope;
  reg [7:0] restart;
  reg [1:0] dly;
  reg [3:0] opt;
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      scope   <= `ORSQ_SCOPE_RST;
      restart <= `ORSQ_RESTART_RST;
      dly     <= `ORSQ_DLY_RST;
      opt     <= {`ORSQ_THFAST_RST, `ORSQ_PDFAST_RST,
                  `ORSQ_WDHOLD_RST, `ORSQ_AUTOON_RST};
    end else if (FULL_RST_O) begin
      scope   <= `ORSQ_SCOPE_RST;
      restart <= `ORSQ_RESTART_RST;
      dly     <= `ORSQ_DLY_RST;
      opt     <= {`ORSQ_THFAST_RST, `ORSQ_PDFAST_RST,
                  `ORSQ_WDHOLD_RST, `ORSQ_AUTOON_RST};
    end else if (CFG_WE_I) begin
      scope   <= SCOPE_WDATA_I;
      restart <= RESTART_WDATA_I;
      dly     <= DLY_WDATA_I;
      opt     <= OPT_WDATA_I;
    end
  end
  assign SCOPE_O   = scope;
  assign RESTART_O = restart;
  assign DLY_O     = dly;
  assign OPT_O     = opt;

  wire auto_on = opt[0];
  wire wd_hold = opt[1];
  wire pd_fast = opt[2];
  wire th_fast = opt[3];

  // ****************************************
  // Request arbitration
  // ****************************************
  reg [7:0] first_req;
  integer   k;
  always @* begin
    first_req = 8'h00;
    for (k = 7; k >= 0; k = k - 1) begin
      if (OFF_REQ_I[k]) begin
        first_req = 8'h00;
        first_req[k] = 1'b1;
      end
    end
  end
  wire req_any  = |OFF_REQ_I;
  wire is_full  = |(first_req & scope);
  wire is_cold  = |(first_req & restart);
  wire fast_off = (first_req[`ORSQ_SRC_PDN] & pd_fast) |
                  (first_req[`ORSQ_SRC_THM] & th_fast);

  // ****************************************
  // Sequencer
  // ****************************************
  reg  [2:0]  state;
  reg  [2:0]  step;
  reg         lat_full;
  reg         lat_cold;
  reg         from_sleep;
  reg         tmr_start;
  reg  [15:0] tmr_load;
  wire        tmr_done;
  wire [15:0] dly_cyc = DLY_UNIT[15:0] * {14'h0000, dly};
  wire [2:0]  last    = NRES[2:0] - 3'h1;

  orsq_step_timer #(.WIDTH(16)) u_tmr (
    .clk_i   (CLK_I),
    .rstn_i  (RSTN_I),
    .start_i (tmr_start),
    .load_i  (tmr_load),
    .done_o  (tmr_done)
  );

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state        <= ST_BACKUP;
      step         <= 3'h0;
      lat_full     <= 1'b0;
      lat_cold     <= 1'b0;
      from_sleep   <= 1'b0;
      tmr_start    <= 1'b0;
      tmr_load     <= 16'h0000;
      RES_EN_O     <= {NRES{1'b0}};
      RES_SLEEP_O  <= {NRES{1'b0}};
      DEVICE_ON_O  <= 1'b0;
      FULL_RST_O   <= 1'b0;
      SWOFF_RST_O  <= 1'b0;
      ACTIVE_SRC_O <= 8'h00;
    end else begin
      tmr_start   <= 1'b0;
      FULL_RST_O  <= 1'b0;
      SWOFF_RST_O <= 1'b0;
      if (DEVICE_ON_CLR_I) begin
        DEVICE_ON_O <= 1'b0;
      end
      if (low_supply && state != ST_BACKUP) begin
        state       <= ST_BACKUP;
        RES_EN_O    <= {NRES{1'b0}};
        RES_SLEEP_O <= {NRES{1'b0}};
        DEVICE_ON_O <= 1'b0;
      end else begin
        case (state)
          ST_BACKUP: begin
            if (supply_ok && !low_supply) begin
              state <= ST_OFF;
            end
          end
          ST_OFF: begin
            if ((ON_REQ_I || lat_cold) && !ON_GATE_I) begin
              lat_cold  <= 1'b0;
              step      <= 3'h0;
              tmr_start <= 1'b1;
              tmr_load  <= `ORSQ_STEP_CYC;
              state     <= ST_ON_SEQ;
            end
          end
          ST_ON_SEQ: begin
            if (tmr_done) begin
              RES_EN_O[step] <= 1'b1;
              if (step == last) begin
                state <= ST_ACTIVE;
                if (auto_on) begin
                  DEVICE_ON_O <= 1'b1;
                end
              end else begin
                step      <= step + 3'h1;
                tmr_start <= 1'b1;
                tmr_load  <= `ORSQ_STEP_CYC;
              end
            end
          end
          ST_ACTIVE, ST_SLEEP: begin
            if (req_any) begin
              ACTIVE_SRC_O <= first_req;
              lat_full     <= is_full;
              lat_cold     <= is_cold;
              from_sleep   <= (state == ST_SLEEP);
              step         <= last;
              tmr_start    <= 1'b1;
              if (state == ST_ACTIVE && dly != 2'h0 && !fast_off) begin
                tmr_load <= dly_cyc;
                state    <= ST_DELAY;
              end else begin
                tmr_load <= fast_off ? `ORSQ_FAST_CYC : `ORSQ_STEP_CYC;
                state    <= ST_OFFSEQ;
              end
            end else if (state == ST_ACTIVE && SLEEP_REQ_I) begin
              RES_SLEEP_O <= RES_EN_O;
              state       <= ST_SLEEP;
            end else if (state == ST_SLEEP && !SLEEP_REQ_I) begin
              RES_SLEEP_O <= {NRES{1'b0}};
              state       <= ST_ACTIVE;
            end
          end
          ST_DELAY: begin
            if (tmr_done) begin
              tmr_start <= 1'b1;
              tmr_load  <= `ORSQ_STEP_CYC;
              state     <= ST_OFFSEQ;
            end
          end
          ST_OFFSEQ: begin
            if (tmr_done) begin
              RES_EN_O[step]    <= 1'b0;
              RES_SLEEP_O[step] <= 1'b0;
              if (step == 3'h0) begin
                state <= ST_RESET;
              end else begin
                step      <= step - 3'h1;
                tmr_start <= 1'b1;
                tmr_load  <= `ORSQ_STEP_CYC;
              end
            end
          end
          ST_RESET: begin
            FULL_RST_O  <= lat_full;
            SWOFF_RST_O <= ~lat_full;
            DEVICE_ON_O <= 1'b0;
            state       <= ST_OFF;
          end
          default: begin
            state <= ST_BACKUP;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      STATE_O   <= ST_BACKUP;
      WDT_RUN_O <= 1'b0;
    end else begin
      STATE_O   <= state;
      WDT_RUN_O <= (state == ST_ACTIVE) ||
                   (state == ST_SLEEP && !wd_hold);
    end
  end
endmodule

// ### orsq_top_monitor.sv
`timescale 1ns/1ps
module orsq_chk_monitor #(
  parameter NRES = 8
) (
  input wire            CLK_I,
  input wire            RSTN_I,
  input wire [7:0]      OFF_REQ_I,
  input wire            ON_REQ_I,
  input wire            ON_GATE_I,
  input wire [7:0]      SCOPE_O,
  input wire [7:0]      RESTART_O,
  input wire [1:0]      DLY_O,
  input wire [3:0]      OPT_O,
  input wire [2:0]      STATE_O,
  input wire [NRES-1:0] RES_EN_O,
  input wire            DEVICE_ON_O,
  input wire            FULL_RST_O,
  input wire            SWOFF_RST_O,
  input wire            WDT_RUN_O,
  input wire [7:0]      ACTIVE_SRC_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  wire hit = |(ACTIVE_SRC_O & SCOPE_O);
  wire cold = |(ACTIVE_SRC_O & RESTART_O);
  a_off_take: assert property (STATE_O == 3'h3 && |OFF_REQ_I && DLY_O == 2'h0 |-> ##2
    STATE_O == 3'h6) else $error("off sequence not started");
  a_first_wins: assert property ((STATE_O == 3'h3 || STATE_O == 3'h4) && |OFF_REQ_I |=>
    ACTIVE_SRC_O == $past(OFF_REQ_I & (~OFF_REQ_I + 8'h01))) else $error("wrong source");
  a_full_kind: assert property (FULL_RST_O |-> hit) else $error("full reset wrong");
  a_swoff_kind: assert property (SWOFF_RST_O |-> !hit) else $error("switchoff wrong");
  a_full_restore: assert property (FULL_RST_O |=> SCOPE_O == 8'h7d &&
    RESTART_O == 8'h34) else $error("defaults not restored");
  a_cold_start: assert property ((FULL_RST_O || SWOFF_RST_O) && cold && !ON_GATE_I
    |-> ##[1:2] STATE_O == 3'h2) else $error("no restart");
  a_stay_off: assert property ((FULL_RST_O || SWOFF_RST_O) && !cold && !ON_REQ_I
    |=> (STATE_O == 3'h1)[*4]) else $error("left off");
  a_seq_order: assert property (
    (RES_EN_O & (RES_EN_O + {{(NRES-1){1'b0}}, 1'b1})) == {NRES{1'b0}})
    else $error("enable order broken");
  a_wdt_hold: assert property ((STATE_O == 3'h4)[*2] ##0 OPT_O[1] |-> !WDT_RUN_O)
    else $error("watchdog runs in sleep");
  a_backup_off: assert property (STATE_O == 3'h0 |-> RES_EN_O == 0)
    else $error("enables in backup");
  a_auto_on: assert property ($rose(STATE_O == 3'h3) && $past(STATE_O) == 3'h2 &&
    OPT_O[0] |-> ##[0:2] DEVICE_ON_O) else $error("device-on not set");
  c_delay: cover property (STATE_O == 3'h5);
  c_sleep: cover property (STATE_O == 3'h4);
  c_swoff: cover property (SWOFF_RST_O);
endmodule
bind orsq_top orsq_chk_monitor #(.NRES(NRES)) orsq_chk_monitor_inst (.*);

// ### orsq_supply_model.sv
`timescale 1ns/1ps
module orsq_supply_model (
  input  wire clk_i,  // Clock
  input  wire drop_i, // Command supply fall
  output reg  low_o,  // Below threshold
  output reg  ok_o    // Above threshold
);
  // Comparator pair always disagree; supply starts good
  initial begin
    low_o = 1'b0;
    ok_o = 1'b1;
  end
  always @(posedge clk_i) begin
    low_o <= drop_i;
    ok_o <= !drop_i;
  end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0, rstn = 1'b0, on = 1'b0, slp = 1'b0, we = 1'b0, drop = 1'b0, gt = 1'b0;
  reg [7:0] off = 8'h00, sw = 8'h00, rw = 8'h00;
  reg [1:0] dw = 2'h0;
  reg [3:0] ow = 4'h0;
  wire low, ok, don, frst, srst, wdt;
  wire [7:0] sc, rs, en, sl, src;
  wire [1:0] dl;
  wire [3:0] op;
  wire [2:0] st;
  integer error_cnt = 0, checks_done = 0, full_cnt = 0, swo_cnt = 0;
  always #12.5 clk = ~clk;
  orsq_supply_model orsq_supply_model_inst (.clk_i(clk), .drop_i(drop), .low_o(low), .ok_o(ok));
  orsq_top #(.DLY_UNIT(4)) orsq_top_inst (.CLK_I(clk), .RSTN_I(rstn), .OFF_REQ_I(off),
    .ON_REQ_I(on), .ON_GATE_I(gt), .SLEEP_REQ_I(slp), .LOW_SUPPLY_I(low), .SUPPLY_OK_I(ok),
    .DEVICE_ON_CLR_I(1'b0), .CFG_WE_I(we), .SCOPE_WDATA_I(sw), .RESTART_WDATA_I(rw),
    .DLY_WDATA_I(dw), .OPT_WDATA_I(ow), .SCOPE_O(sc), .RESTART_O(rs), .DLY_O(dl), .OPT_O(op),
    .STATE_O(st), .RES_EN_O(en), .RES_SLEEP_O(sl), .DEVICE_ON_O(don), .FULL_RST_O(frst),
    .SWOFF_RST_O(srst), .WDT_RUN_O(wdt), .ACTIVE_SRC_O(src));
  always @(posedge clk) begin
    if (frst === 1'b1) full_cnt = full_cnt + 1;
    if (srst === 1'b1) swo_cnt = swo_cnt + 1;
  end
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [7:0] g, input [7:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        error_cnt = error_cnt + 1;
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #2;
    end
  endtask
  // Bounded wait for a power state; a stall ends the run
  task wait_st(input [2:0] s);
    integer n;
    begin
      n = 0;
      while (st !== s && n < 800) begin
        tick(1);
        n = n + 1;
      end
      chk({5'h00, st}, {5'h00, s});
      if (st !== s) close_out;
    end
  endtask
  task pulse_off(input [7:0] v);
    begin
      off = v;
      tick(1);
      off = 8'h00;
    end
  endtask
  task power_on;
    begin
      on = 1'b1;
      tick(1);
      on = 1'b0;
      wait_st(3'h3);
    end
  endtask
  initial begin
    tick(8);
    rstn = 1'b1;
    chk(sc, 8'h7d);
    chk(rs, 8'h34);
    chk({6'h00, dl}, 8'h00);
    chk({4'h0, op}, 8'h02);
    wait_st(3'h1);
    power_on;
    chk(en, 8'hff);
    chk({7'h00, don}, 8'h00);
    chk({7'h00, wdt}, 8'h01);
    $display("test defaults and start done");
    pulse_off(8'h0c);
    wait_st(3'h6);
    chk(src, 8'h04);
    wait_st(3'h3);
    chk(full_cnt[7:0], 8'h01);
    $display("test watchdog cold reset done");
    pulse_off(8'h02);
    wait_st(3'h6);
    // A fast off would already have dropped the top enable here
    tick(4);
    chk(en, 8'hff);
    wait_st(3'h1);
    tick(20);
    chk({5'h00, st}, 8'h01);
    chk(swo_cnt[7:0], 8'h01);
    chk(en, 8'h00);
    $display("test powerdown shutdown done");
    sw = 8'h7d;
    rw = 8'h20;
    dw = 2'h1;
    ow = 4'h3;
    we = 1'b1;
    tick(1);
    we = 1'b0;
    chk(rs, 8'h20);
    chk({6'h00, dl}, 8'h01);
    power_on;
    tick(3);
    chk({7'h00, don}, 8'h01);
    pulse_off(8'h01);
    wait_st(3'h5);
    chk(en, 8'hff);
    wait_st(3'h1);
    chk(sc, 8'h7d);
    chk(rs, 8'h34);
    // Let the stay-off window pass before the next ON request
    tick(4);
    $display("test delay and auto-on done");
    power_on;
    slp = 1'b1;
    wait_st(3'h4);
    chk(sl, 8'hff);
    tick(3);
    chk({7'h00, wdt}, 8'h00);
    pulse_off(8'h20);
    slp = 1'b0;
    wait_st(3'h6);
    gt = 1'b1;
    wait_st(3'h1);
    tick(4);
    chk({5'h00, st}, 8'h01);
    gt = 1'b0;
    wait_st(3'h3);
    chk(full_cnt[7:0], 8'h03);
    $display("test sleep and software reset done");
    drop = 1'b1;
    wait_st(3'h0);
    chk(en, 8'h00);
    drop = 1'b0;
    wait_st(3'h1);
    $display("test low supply done");
    close_out;
  end
endmodule
